// ---- acs_top.sv ----
// Converter control and status logic with an AXI4-Lite register port.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "acs_map.svh"
// Summary of operation
// - Done flag bit 7 sets on completion; cleared by result read or control write.
// - Power bit 5 written by software; zero switches converter off, one on.
// - Reserved bit 4 always reads zero.
// - Selector bits 2:0 route input 0 to 7 to the converter.
// - Eight-bit read-only result register spanning 00h to FFh.
// - Reset clears control and result registers: off, input 0, flag clear.
// - While powered, conversions repeat back to back on the selected input.
// - Control write aborts conversion, clears flag, starts a fresh conversion when it sets power bit 5.
// - Each conversion takes 64 cycles including sampling; completion sets the interrupt status bit, driven onto irq when masked in.
module acs_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  core_result,
    output logic             converter_power_on,
    output logic [2:0]       input_selector,
    output logic             sample_enable,
    output logic             irq
);
    logic [7:0]  control_status_reg;
    logic [7:0]  next_csr;
    logic        irq_status;
    logic        next_irq_status;
    logic        irq_mask;
    logic        next_irq_mask;
    logic        aw_held;
    logic        next_aw_held;
    logic [11:0] aw_addr;
    logic [11:0] next_aw_addr;
    logic        w_held;
    logic        next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic        next_awready;
    logic        next_wready;
    logic        next_arready;
    logic        next_irq;
    logic        next_sample_enable;
    logic        do_write;
    logic        do_read;
    logic        csr_write;
    logic        result_read;
    logic        seq_sampling;
    logic        seq_done;
    logic [7:0]  result;

    acs_sequencer acs_sequencer_i (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .power_on   (control_status_reg[`ACS_BIT_POWER]),
        .restart    (csr_write),
        .sampling   (seq_sampling),
        .done_pulse (seq_done)
    );

    acs_result_capture acs_result_capture_i (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .core_result (core_result),
        .capture     (seq_done),
        .result      (result)
    );

    // A write completes once both address and data are held and no response is pending.
    assign do_write    = aw_held && w_held && !s_axi_bvalid;
    assign do_read     = s_axi_arvalid && s_axi_arready;
    assign csr_write   = do_write && aw_addr == `ACS_ADDR_CSR && w_strb[`ACS_WSTRB_LOW];
    assign result_read = do_read && s_axi_araddr == `ACS_ADDR_RESULT;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_addr == `ACS_ADDR_CSR || aw_addr == `ACS_ADDR_RESULT
                || aw_addr == `ACS_ADDR_IRQ_STATUS || aw_addr == `ACS_ADDR_IRQ_MASK) begin
                next_bresp = `ACS_RESP_OKAY;
            end else begin
                next_bresp = `ACS_RESP_SLVERR;
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    always_comb begin
        next_csr        = control_status_reg;
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (csr_write) begin
            next_csr[`ACS_BIT_POWER]              = w_data[`ACS_BIT_POWER];
            next_csr[`ACS_SEL_HI:`ACS_SEL_LO]     = w_data[`ACS_SEL_HI:`ACS_SEL_LO];
            next_csr[`ACS_BIT_RSV6]               = w_data[`ACS_BIT_RSV6];
            next_csr[`ACS_BIT_RSV3]               = w_data[`ACS_BIT_RSV3];
            next_csr[`ACS_BIT_DONE]               = 1'b0;
        end else if (result_read) begin
            next_csr[`ACS_BIT_DONE] = 1'b0;
        end
        // Completion wins over a same-cycle read clear; a same-cycle control write clears it.
        if (seq_done && !csr_write) begin
            next_csr[`ACS_BIT_DONE] = 1'b1;
        end
        next_csr[`ACS_BIT_RSV4] = 1'b0;
        if (do_write && aw_addr == `ACS_ADDR_IRQ_STATUS && w_strb[`ACS_WSTRB_LOW]
            && w_data[`ACS_IRQ_DONE_BIT]) begin
            next_irq_status = 1'b0;
        end
        if (do_write && aw_addr == `ACS_ADDR_IRQ_MASK && w_strb[`ACS_WSTRB_LOW]) begin
            next_irq_mask = w_data[`ACS_IRQ_DONE_BIT];
        end
        if (seq_done) begin
            next_irq_status = 1'b1;
        end
        next_irq = next_irq_status && next_irq_mask;
        next_sample_enable = seq_sampling && next_csr[`ACS_BIT_POWER];
    end

    always_comb begin
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = `ACS_RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr == `ACS_ADDR_RESULT) begin
                next_rdata[7:0] = result;
            end else if (s_axi_araddr == `ACS_ADDR_CSR) begin
                next_rdata[7:0] = control_status_reg;
            end else if (s_axi_araddr == `ACS_ADDR_IRQ_STATUS) begin
                next_rdata[`ACS_IRQ_DONE_BIT] = irq_status;
            end else if (s_axi_araddr == `ACS_ADDR_IRQ_MASK) begin
                next_rdata[`ACS_IRQ_DONE_BIT] = irq_mask;
            end else begin
                next_rresp = `ACS_RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_status_reg                <= `ACS_RESET_BYTE;
            irq_status         <= 1'b0;
            irq_mask           <= 1'b0;
            aw_held            <= 1'b0;
            aw_addr            <= 12'h000;
            w_held             <= 1'b0;
            w_data             <= 32'h0000_0000;
            w_strb             <= 4'h0;
            s_axi_awready      <= 1'b0;
            s_axi_wready       <= 1'b0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= `ACS_RESP_OKAY;
            s_axi_arready      <= 1'b0;
            s_axi_rvalid       <= 1'b0;
            s_axi_rresp        <= `ACS_RESP_OKAY;
            s_axi_rdata        <= 32'h0000_0000;
            converter_power_on <= 1'b0;
            input_selector     <= 3'h0;
            sample_enable      <= 1'b0;
            irq                <= 1'b0;
        end else begin
            control_status_reg                <= next_csr;
            irq_status         <= next_irq_status;
            irq_mask           <= next_irq_mask;
            aw_held            <= next_aw_held;
            aw_addr            <= next_aw_addr;
            w_held             <= next_w_held;
            w_data             <= next_w_data;
            w_strb             <= next_w_strb;
            s_axi_awready      <= next_awready;
            s_axi_wready       <= next_wready;
            s_axi_bvalid       <= next_bvalid;
            s_axi_bresp        <= next_bresp;
            s_axi_arready      <= next_arready;
            s_axi_rvalid       <= next_rvalid;
            s_axi_rresp        <= next_rresp;
            s_axi_rdata        <= next_rdata;
            converter_power_on <= next_csr[`ACS_BIT_POWER];
            input_selector     <= next_csr[`ACS_SEL_HI:`ACS_SEL_LO];
            sample_enable      <= next_sample_enable;
            irq                <= next_irq;
        end
    end
endmodule

// ---- acs_map.svh ----
// Register offsets, field positions, reset values and timing counts of the converter block.
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_IDX_RESULT        8'h70
`define ACS_IDX_CSR           8'h71
`define ACS_IDX_IRQ_STATUS    8'h72
`define ACS_IDX_IRQ_MASK      8'h73
`define ACS_ADDR_RESULT       12'h1C0
`define ACS_ADDR_CSR          12'h1C4
`define ACS_ADDR_IRQ_STATUS   12'h1C8
`define ACS_ADDR_IRQ_MASK     12'h1CC
`define ACS_BIT_DONE          7
`define ACS_BIT_RSV6          6
`define ACS_BIT_POWER         5
`define ACS_BIT_RSV4          4
`define ACS_BIT_RSV3          3
`define ACS_SEL_HI            2
`define ACS_SEL_LO            0
`define ACS_RESET_BYTE        8'h00
`define ACS_IRQ_DONE_BIT      0
`define ACS_CONV_CYCLES       64
`define ACS_SAMPLE_CYCLES     32
`define ACS_CNT_LAST          6'h3F
`define ACS_CNT_SAMPLE_LAST   6'h1F
`define ACS_RESP_OKAY         2'h0
`define ACS_RESP_SLVERR       2'h2
`define ACS_WSTRB_LOW         0
`endif

// ---- acs_pkg.sv ----
// Types shared by the converter control files.
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SAMPLE,
        ACS_CONVERT
    } acs_state_t;
endpackage

// ---- acs_sequencer.sv ----
// Conversion sequencer: a 64-cycle sample and approximation loop.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       power_on,
    input  wire logic       restart,
    output logic            sampling,
    output logic            done_pulse
);
    acs_pkg::acs_state_t state;
    acs_pkg::acs_state_t next_state;
    logic [5:0]          count;
    logic [5:0]          next_count;
    logic                next_done_pulse;

    always_comb begin
        next_state      = state;
        next_count      = count;
        next_done_pulse = 1'b0;
        if (!power_on) begin
            next_state = acs_pkg::ACS_IDLE;
            next_count = 6'h00;
        end else if (restart || state == acs_pkg::ACS_IDLE) begin
            next_state = acs_pkg::ACS_SAMPLE;
            next_count = 6'h00;
        end else begin
            next_count = count + 6'h01;
            case (state)
                acs_pkg::ACS_SAMPLE: begin
                    if (count == `ACS_CNT_SAMPLE_LAST) begin
                        next_state = acs_pkg::ACS_CONVERT;
                    end
                end
                acs_pkg::ACS_CONVERT: begin
                    if (count == `ACS_CNT_LAST) begin
                        next_state      = acs_pkg::ACS_SAMPLE;
                        next_count      = 6'h00;
                        next_done_pulse = 1'b1;
                    end
                end
                default: begin
                    next_state = acs_pkg::ACS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= acs_pkg::ACS_IDLE;
            count      <= 6'h00;
            done_pulse <= 1'b0;
        end else begin
            state      <= next_state;
            count      <= next_count;
            done_pulse <= next_done_pulse;
        end
    end

    assign sampling = (state == acs_pkg::ACS_SAMPLE);
endmodule

// ---- acs_result_capture.sv ----
// Synchronises the converter core's result byte and latches it at each completion.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_result_capture (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] core_result,
    input  wire logic       capture,
    output logic [7:0]      result
);
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] next_result;

    always_comb begin
        next_result = capture ? sync_b : result;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= `ACS_RESET_BYTE;
            sync_b <= `ACS_RESET_BYTE;
            result <= `ACS_RESET_BYTE;
        end else begin
            sync_a <= core_result;
            sync_b <= sync_a;
            result <= next_result;
        end
    end
endmodule

// ---- acs_top_chk.sv ----
// Port assertions for the converter control block.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_top_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        converter_power_on,
    input wire logic [2:0]  input_selector,
    input wire logic        sample_enable
);
    logic [11:0] wa, ra;
    logic [7:0]  wd;
    logic [6:0]  per, hi;
    logic        ws, se_q, dirty;
    // Any write since the last sampling start may restart the sequencer, so timing checks skip.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {wa, ra, wd, ws, se_q, dirty} <= '0;
            per <= 7'h7F;
            hi <= 7'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
            if (s_axi_wvalid && s_axi_wready) {ws, wd} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            se_q <= sample_enable;
            per <= (sample_enable && !se_q) ? 7'h01 : ((per == 7'h7F) ? per : per + 7'h01);
            hi <= sample_enable ? hi + 7'h01 : 7'h00;
            dirty <= (sample_enable && !se_q) ? s_axi_bvalid : (dirty | s_axi_bvalid);
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence csr_applied;
        $rose(s_axi_bvalid) && wa == `ACS_ADDR_CSR && ws;
    endsequence
    AST_WRITE_ANSWER: assert property (wr_taken |=> ##[0:3] s_axi_bvalid)
        else $error("write response missing");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> ##[0:3] s_axi_rvalid)
        else $error("read data missing");
    AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_RSV4_ZERO: assert property (s_axi_rvalid && ra == `ACS_ADDR_CSR |-> !s_axi_rdata[4])
        else $error("reserved control bit reads one");
    AST_CSR_OUTPUTS: assert property (csr_applied |-> input_selector == wd[2:0] && converter_power_on == wd[5])
        else $error("selector or power output not following write");
    AST_POWER_IDLE: assert property (!converter_power_on [*2] |-> !sample_enable)
        else $error("sampling while switched off");
    AST_SAMPLE_LEN: assert property ($fell(sample_enable) && !dirty && !s_axi_bvalid |-> hi == 7'd32)
        else $error("sampling phase length wrong");
    AST_PERIOD: assert property ($rose(sample_enable) && !dirty && !s_axi_bvalid && per != 7'h7F |-> per == 7'd64)
        else $error("conversion period wrong");
endmodule
bind acs_top acs_top_chk acs_top_chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .converter_power_on, .input_selector, .sample_enable);

// ---- acs_conv_model.sv ----
// Behavioural analog multiplexer and converter core at the block's far side.
`timescale 1ns/1ps
module acs_conv_model (
    input  wire logic       aclk,
    input  wire logic       converter_power_on,
    input  wire logic [2:0] input_selector,
    output logic      [7:0] core_result
);
    initial core_result = 8'h3C;
    // Switched off, the core output is meaningless, so it toggles every cycle.
    always @(posedge aclk) begin
        if (!converter_power_on) begin
            core_result <= ~core_result;
        end else begin
            case (input_selector)
                3'h0: core_result <= 8'h00;
                3'h7: core_result <= 8'hFF;
                default: core_result <= {input_selector, 5'h0A};
            endcase
        end
    end
endmodule

// ---- acs_top_tb.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_top_tb;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, converter_power_on, sample_enable, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  core_result;
    logic [2:0]  input_selector;
    int          failures, compares;
    acs_top acs_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_result,
        .converter_power_on, .input_selector, .sample_enable, .irq);
    acs_conv_model acs_conv_model_i (.aclk, .converter_power_on, .input_selector, .core_result);
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bvalid), 32'h1);
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic axi_r(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rvalid), 32'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic poll(input logic [11:0] a, input int b);
        int n;
        n = 0;
        do begin
            axi_r(a, rd, rs);
            n++;
        end while (rd[b] !== 1'b1 && n < 40);
        chk(32'(rd[b]), 32'h1);
    endtask
    function automatic logic [31:0] level(input logic [2:0] s);
        return (s == 3'h0) ? 32'h00 : (s == 3'h7) ? 32'hFF : {24'h0, s, 5'h0A};
    endfunction
    task automatic t_reset();
        axi_r(`ACS_ADDR_RESULT, rd, rs);
        chk(rd, 32'h0);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h0);
        chk({27'h0, irq, converter_power_on, input_selector}, 32'h0);
    endtask
    task automatic t_fields();
        axi_w(`ACS_ADDR_CSR, 32'h37, `ACS_RESP_OKAY);
        chk({28'h0, converter_power_on, input_selector}, 32'hF);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h27);
        repeat (6000) @(posedge aclk);
    endtask
    task automatic t_timing();
        axi_w(`ACS_ADDR_CSR, 32'h25, `ACS_RESP_OKAY);
        repeat (50) @(posedge aclk);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h25);
        repeat (15) @(posedge aclk);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'hA5);
        axi_r(`ACS_ADDR_RESULT, rd, rs);
        chk(rd, level(3'h5));
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h25);
        poll(`ACS_ADDR_CSR, 7);
    endtask
    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            axi_w(`ACS_ADDR_CSR, 32'h20 | s, `ACS_RESP_OKAY);
            axi_r(`ACS_ADDR_CSR, rd, rs);
            chk(rd, 32'h20 | s);
            poll(`ACS_ADDR_CSR, 7);
            axi_r(`ACS_ADDR_RESULT, rd, rs);
            chk(rd, level(3'(s)));
        end
    endtask
    task automatic t_irq_off();
        axi_w(`ACS_ADDR_IRQ_MASK, 32'h0, `ACS_RESP_OKAY);
        axi_w(`ACS_ADDR_IRQ_STATUS, 32'h1, `ACS_RESP_OKAY);
        poll(`ACS_ADDR_IRQ_STATUS, 0);
        chk(32'(irq), 32'h0);
        axi_w(`ACS_ADDR_IRQ_MASK, 32'h1, `ACS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        axi_w(`ACS_ADDR_CSR, 32'h07, `ACS_RESP_OKAY);
        repeat (200) @(posedge aclk);
        chk({30'h0, converter_power_on, sample_enable}, 32'h0);
        axi_r(`ACS_ADDR_RESULT, rd, rs);
        chk(rd, 32'hFF);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h07);
        chk(32'(irq), 32'h1);
        axi_w(`ACS_ADDR_IRQ_STATUS, 32'h1, `ACS_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        axi_r(`ACS_ADDR_IRQ_STATUS, rd, rs);
        chk(rd, 32'h0);
    endtask
    task automatic t_unmapped();
        axi_w(12'h1D0, 32'h5A, `ACS_RESP_SLVERR);
        axi_r(12'h1D0, rd, rs);
        chk({rd[29:0], rs}, {30'h0, `ACS_RESP_SLVERR});
        axi_w(`ACS_ADDR_RESULT, 32'h5A, `ACS_RESP_OKAY);
        axi_r(`ACS_ADDR_RESULT, rd, rs);
        chk(rd, 32'hFF);
        s_axi_wstrb <= 4'hE;
        axi_w(`ACS_ADDR_CSR, 32'h25, `ACS_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        chk(32'(converter_power_on), 32'h0);
        axi_r(`ACS_ADDR_CSR, rd, rs);
        chk(rd, 32'h07);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        failures = 0;
        compares = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_timing();
        t_select();
        t_irq_off();
        t_unmapped();
        tally_and_finish();
    end
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule
